/* core/tocc_core.sv */
// Control part of an 8-channel 16-bit timer: enables, prescaler, fast flag clear,
// toggle-on-overflow and compare output actions with channel 7 override.
// Assumes counter, flags and capture logic sit outside, on the same bus clock.
//
// Notes on behaviour
// - Count enable low halts timer and counter; high runs normally.
// - Divide-by-64 accumulator clock comes straight from the bus clock; absent when timer inactive.
// - Stop-in-wait plus wait mode halts timer and accumulator clock.
// - Stop-in-freeze halts counter in freeze; accumulator clock keeps running.
// - Fast clear off: data accesses never clear flags.
// - Fast clear on: capture read or compare write clears that channel flag.
// - Fast clear on: any counter byte access clears overflow flag.
// - Fast clear on: accumulator count access clears both accumulator flags.
// - Precision select picks legacy three-bit field or full precision prescaler.
// - Precision select takes only its first write after reset.
// - Toggle-on-overflow inverts compare-mode channel output at each overflow.
// - Overflow toggle beats forced action; channel 7 override beats toggle.
// - Action pair: 00 none, 01 toggle, 10 low, 11 high.
// - Nonzero action pair makes the pin an output of compare logic.
// - Pin driven only while its disconnect bit is clear.
// - Override priority applies only with channel 7 and x in compare mode.
// - Masked channel with earlier own match sees both events at each match.
// - Mask 7 set: channel 7 follows data bit; equal match takes data bit.
// - Channel 7 event copies override data to masked channels 6 to 0.
// - Mode select bit: 0 input capture, 1 output compare.
// - Flag cleared by writing one while timer or accumulator enabled.
`timescale 1ns/1ps
module tocc_core (
  // Clock and reset
  input logic ref_clk_i,
  input logic rst_i,
  // Register port
  input tocc_pkg::tocc_bus_t bus_i,
  output logic [7:0] rdata_o,
  // System modes and neighbouring registers
  input logic wait_mode_i,
  input logic freeze_mode_i,
  input logic accum_enable_i,
  input logic [7:0] channel_mode_select_i,
  input logic [7:0] override_mask_i,
  input logic [7:0] override_data_i,
  input logic [7:0] pin_disconnect_bit_i,
  input logic [2:0] legacy_prescaler_field_i,
  input logic [7:0] precision_prescaler_register_i,
  // Counter and compare events
  input tocc_pkg::tocc_event_t event_i,
  // Timing enables
  output logic count_tick_o,
  output logic div64_tick_o,
  output logic timer_run_o,
  output logic accum_run_o,
  // Flag clear pulses
  output logic [7:0] channel_flag_clr_o,
  output logic overflow_flag_clr_o,
  output logic accum_overflow_flag_clr_o,
  output logic accum_input_flag_clr_o,
  // Timer port pins
  output logic [7:0] channel_pin_o,
  output logic [7:0] channel_pin_oe_o
);
  logic [7:0] ctrl_q;
  logic [7:0] toggle_q;
  logic [15:0] action_q;
  logic prec_lock_q;
  logic [7:0] rdata_q;
  logic [7:0] presc_q;
  logic [5:0] div64_q;
  logic count_tick_q;
  logic div64_tick_q;
  logic timer_run_q;
  logic accum_run_q;
  logic [7:0] chan_clr_q;
  logic ovf_clr_q;
  logic acc_clr_q;
  logic [7:0] force_q;
  logic [7:0] pin_q;
  logic [7:0] oe_q;
  logic wait_stop;
  logic timer_active;
  logic counter_run;
  logic [7:0] presc_last;
  logic fast;
  logic chan_hit;
  logic cnt_hit;
  logic acc_hit;
  logic flag_wr_ok;
  logic [2:0] chan_idx;
  logic [7:0] chan_fast;
  logic ev7;

  assign wait_stop = wait_mode_i & ctrl_q[tocc_pkg::BIT_STOP_WAIT];
  assign timer_active = ctrl_q[tocc_pkg::BIT_COUNT_EN] & ~wait_stop;
  assign counter_run = timer_active & ~(freeze_mode_i & ctrl_q[tocc_pkg::BIT_STOP_FRZ]);

  // Legacy field is a power of two; precision register divides by value plus one
  always_comb begin
    if (ctrl_q[tocc_pkg::BIT_PREC_SEL]) begin
      presc_last = precision_prescaler_register_i;
    end else begin
      presc_last = 8'((9'h001 << legacy_prescaler_field_i) - 9'h001);
    end
  end

  // Register writes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= tocc_pkg::RST_CTRL;
      toggle_q <= tocc_pkg::RST_TOGGLE;
      action_q <= tocc_pkg::RST_ACTION;
      prec_lock_q <= 1'b0;
    end else if (bus_i.wr) begin
      unique case (bus_i.addr)
        tocc_pkg::ADDR_SYS_CTRL1: begin
          ctrl_q[7:4] <= bus_i.wdata[7:4];
          if (!prec_lock_q) begin
            ctrl_q[tocc_pkg::BIT_PREC_SEL] <= bus_i.wdata[tocc_pkg::BIT_PREC_SEL];
          end
          prec_lock_q <= 1'b1;
        end
        tocc_pkg::ADDR_OVF_TOGGLE: toggle_q <= bus_i.wdata;
        tocc_pkg::ADDR_ACT_UPPER: action_q[15:8] <= bus_i.wdata;
        tocc_pkg::ADDR_ACT_LOWER: action_q[7:0] <= bus_i.wdata;
        default: ;
      endcase
    end
  end

  // Read data stands for the single cycle after the strobe
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else if (bus_i.rd) begin
      unique case (bus_i.addr)
        tocc_pkg::ADDR_SYS_CTRL1: rdata_q <= ctrl_q & tocc_pkg::CTRL_WR_MASK;
        tocc_pkg::ADDR_OVF_TOGGLE: rdata_q <= toggle_q;
        tocc_pkg::ADDR_ACT_UPPER: rdata_q <= action_q[15:8];
        tocc_pkg::ADDR_ACT_LOWER: rdata_q <= action_q[7:0];
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  // Prescaler; restarts from zero when halted, so first period after a halt is full
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_q <= 8'h00;
      count_tick_q <= 1'b0;
    end else if (!counter_run) begin
      presc_q <= 8'h00;
      count_tick_q <= 1'b0;
    end else if (presc_q >= presc_last) begin
      presc_q <= 8'h00;
      count_tick_q <= 1'b1;
    end else begin
      presc_q <= presc_q + 8'h01;
      count_tick_q <= 1'b0;
    end
  end

  // Accumulator clock ignores freeze but dies with the timer
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div64_q <= 6'h00;
      div64_tick_q <= 1'b0;
    end else if (!timer_active) begin
      div64_q <= 6'h00;
      div64_tick_q <= 1'b0;
    end else begin
      div64_q <= div64_q + 6'h01;
      div64_tick_q <= (div64_q == tocc_pkg::DIV64_LAST);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      timer_run_q <= 1'b0;
      accum_run_q <= 1'b0;
    end else begin
      timer_run_q <= counter_run;
      accum_run_q <= accum_enable_i & ~wait_stop;
    end
  end

  // Flag clearing by access side effect or by writing ones
  assign fast = ctrl_q[tocc_pkg::BIT_FAST_CLR];
  assign chan_idx = bus_i.addr[3:1];
  assign chan_hit = bus_i.addr >= tocc_pkg::ADDR_CHAN_FIRST
                    && bus_i.addr <= tocc_pkg::ADDR_CHAN_LAST;
  assign cnt_hit = bus_i.addr == tocc_pkg::ADDR_CNT_HI || bus_i.addr == tocc_pkg::ADDR_CNT_LO;
  assign acc_hit = bus_i.addr == tocc_pkg::ADDR_ACC_CNT_HI
                   || bus_i.addr == tocc_pkg::ADDR_ACC_CNT_LO;
  assign flag_wr_ok = ctrl_q[tocc_pkg::BIT_COUNT_EN] | accum_enable_i;

  always_comb begin
    chan_fast = 8'h00;
    if (fast && chan_hit) begin
      // Capture channels clear on read, compare channels on write
      if (channel_mode_select_i[chan_idx] ? bus_i.wr : bus_i.rd) begin
        chan_fast[chan_idx] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chan_clr_q <= 8'h00;
      ovf_clr_q <= 1'b0;
      acc_clr_q <= 1'b0;
    end else begin
      chan_clr_q <= chan_fast
                    | ({8{bus_i.wr && flag_wr_ok && bus_i.addr == tocc_pkg::ADDR_CHAN_FLAGS}}
                       & bus_i.wdata);
      ovf_clr_q <= (fast && cnt_hit && (bus_i.rd || bus_i.wr))
                   || (bus_i.wr && flag_wr_ok && bus_i.addr == tocc_pkg::ADDR_OVF_FLAGS
                       && bus_i.wdata[tocc_pkg::BIT_OVF_FLAG]);
      acc_clr_q <= fast && acc_hit && (bus_i.rd || bus_i.wr);
    end
  end

  // Forced actions are strobed one cycle later, aligned with the pin stage
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      force_q <= 8'h00;
    end else if (bus_i.wr && bus_i.addr == tocc_pkg::ADDR_FORCE) begin
      force_q <= bus_i.wdata;
    end else begin
      force_q <= 8'h00;
    end
  end

  // Channel 7 event: overflow with its toggle bit, or its own compare match
  assign ev7 = channel_mode_select_i[7]
               & ((event_i.overflow & toggle_q[7]) | event_i.compare_match[7]);

  for (genvar ch = 0; ch < 8; ch++) begin : g_chan
    logic om;
    logic ol;
    logic act;
    logic ovr;
    assign om = action_q[2 * ch + 1];
    assign ol = action_q[2 * ch];
    assign ovr = ev7 & override_mask_i[ch] & channel_mode_select_i[ch];
    // A compare on channel 7 with mask bit 7 set is replaced by the override
    assign act = event_i.compare_match[ch] | force_q[ch];

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        pin_q[ch] <= 1'b0;
      end else if (channel_mode_select_i[ch]) begin
        if (ovr) begin
          pin_q[ch] <= override_data_i[ch];
        end else if (event_i.overflow && toggle_q[ch]) begin
          pin_q[ch] <= ~pin_q[ch];
        end else if (act && (om || ol)) begin
          // Own match of a masked channel still acts when it differs from channel 7
          pin_q[ch] <= om ? ol : ~pin_q[ch];
        end
      end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        oe_q[ch] <= 1'b0;
      end else begin
        oe_q[ch] <= channel_mode_select_i[ch] & (om | ol) & ~pin_disconnect_bit_i[ch];
      end
    end
  end

  assign rdata_o = rdata_q;
  assign count_tick_o = count_tick_q;
  assign div64_tick_o = div64_tick_q;
  assign timer_run_o = timer_run_q;
  assign accum_run_o = accum_run_q;
  assign channel_flag_clr_o = chan_clr_q;
  assign overflow_flag_clr_o = ovf_clr_q;
  assign accum_overflow_flag_clr_o = acc_clr_q;
  assign accum_input_flag_clr_o = acc_clr_q;
  assign channel_pin_o = pin_q;
  assign channel_pin_oe_o = oe_q;

  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ctrl_wr_locked;
    prec_lock_q && bus_i.wr && bus_i.addr == tocc_pkg::ADDR_SYS_CTRL1;
  endsequence
  sequence s_fast_cnt_access;
    fast && cnt_hit && (bus_i.rd || bus_i.wr);
  endsequence
  sequence s_fast_acc_access;
    fast && acc_hit && (bus_i.rd || bus_i.wr);
  endsequence
  sequence s_wait_stop_held;
    wait_stop [*2];
  endsequence
  // Own compare on channel 0 with no overflow toggle or override in the same cycle
  sequence s_ch0_drive_high;
    channel_mode_select_i[0] && event_i.compare_match[0] && action_q[1:0] == 2'b11
    && !(ev7 && override_mask_i[0]) && !(event_i.overflow && toggle_q[0]);
  endsequence
  sequence s_ch0_drive_low;
    channel_mode_select_i[0] && event_i.compare_match[0] && action_q[1:0] == 2'b10
    && !(ev7 && override_mask_i[0]) && !(event_i.overflow && toggle_q[0]);
  endsequence
  // Masked channel 1 matching on its own, away from any channel 7 event
  sequence s_masked_own_match;
    !ev7 && override_mask_i[1] && channel_mode_select_i[1] && event_i.compare_match[1]
    && action_q[3:2] == 2'b11 && !(event_i.overflow && toggle_q[1]);
  endsequence

  a_halt_no_tick: assert property (!ctrl_q[tocc_pkg::BIT_COUNT_EN] |=> !count_tick_o && !timer_run_o)
    else $error("Counter tick while timer disabled");
  a_div64_absent: assert property (!ctrl_q[tocc_pkg::BIT_COUNT_EN] [*2] |=> !div64_tick_o)
    else $error("Accumulator clock while timer disabled");
  a_wait_stops_all: assert property (s_wait_stop_held |=> !count_tick_o && !div64_tick_o && !accum_run_o)
    else $error("Timer still running in wait with stop set");
  a_freeze_keeps_acc: assert property (ctrl_q[7] && !wait_stop && freeze_mode_i && ctrl_q[5]
      && div64_q == tocc_pkg::DIV64_LAST |=> !count_tick_o && div64_tick_o)
    else $error("Freeze handling of counter or accumulator clock wrong");
  a_no_side_clear: assert property (!fast && !bus_i.wr |=> channel_flag_clr_o == 8'h00
      && !accum_input_flag_clr_o && !overflow_flag_clr_o)
    else $error("Flag cleared by access with fast clear off");
  a_chan_fast_clr: assert property (fast && chan_hit && bus_i.wr && channel_mode_select_i[chan_idx]
      |=> channel_flag_clr_o[$past(chan_idx)])
    else $error("Compare write did not clear channel flag");
  a_cnt_fast_clr: assert property (s_fast_cnt_access |=> overflow_flag_clr_o)
    else $error("Counter access did not clear overflow flag");
  a_acc_fast_clr: assert property (s_fast_acc_access
      |=> accum_overflow_flag_clr_o && accum_input_flag_clr_o)
    else $error("Accumulator access did not clear both flags");
  a_prec_once: assert property (s_ctrl_wr_locked |=> $stable(ctrl_q[tocc_pkg::BIT_PREC_SEL]))
    else $error("Precision select changed after first write");
  a_ovf_toggle: assert property (channel_mode_select_i[0] && toggle_q[0] && event_i.overflow && !(ev7
      && override_mask_i[0]) |=> channel_pin_o[0] != $past(channel_pin_o[0]))
    else $error("Overflow toggle missing on channel 0");
  a_override_wins: assert property (ev7 && override_mask_i[1] && channel_mode_select_i[1]
      |=> channel_pin_o[1] == $past(override_data_i[1]))
    else $error("Channel 7 override lost on channel 1");
  a_pin_drive: assert property (pin_disconnect_bit_i[2] |=> !channel_pin_oe_o[2])
    else $error("Pin driven while disconnected");
  a_pair_drives_high: assert property (s_ch0_drive_high |=> channel_pin_o[0])
    else $error("Compare with pair 11 did not set pin");
  a_pair_drives_low: assert property (s_ch0_drive_low |=> !channel_pin_o[0])
    else $error("Compare with pair 10 did not clear pin");
  a_pair_enables_pin: assert property (channel_mode_select_i[0] && action_q[1:0] != 2'b00
      && !pin_disconnect_bit_i[0] |=> channel_pin_oe_o[0])
    else $error("Nonzero action pair did not drive pin");
  a_capture_no_drive: assert property (!channel_mode_select_i[0] |=> !channel_pin_oe_o[0])
    else $error("Capture channel pin driven");
  a_capture_holds: assert property (!channel_mode_select_i[1] |=> $stable(channel_pin_o[1]))
    else $error("Capture channel pin changed");
  a_mask7_follows: assert property (ev7 && override_mask_i[7]
      |=> channel_pin_o[7] == $past(override_data_i[7]))
    else $error("Channel 7 did not follow its override data");
  a_masked_own_act: assert property (s_masked_own_match |=> channel_pin_o[1])
    else $error("Masked channel ignored its own compare");
  a_flag_wr_clr: assert property (bus_i.wr && flag_wr_ok
      && bus_i.addr == tocc_pkg::ADDR_CHAN_FLAGS
      |=> (channel_flag_clr_o & $past(bus_i.wdata)) == $past(bus_i.wdata))
    else $error("Write of ones did not clear channel flags");
  a_ovf_wr_clr: assert property (bus_i.wr && flag_wr_ok && bus_i.addr == tocc_pkg::ADDR_OVF_FLAGS
      && bus_i.wdata[tocc_pkg::BIT_OVF_FLAG] |=> overflow_flag_clr_o)
    else $error("Write of one did not clear overflow flag");
  // Spacing is only checked for the divide-by-four setting that the bench uses
  a_prec_spacing: assert property (count_tick_o && ctrl_q[tocc_pkg::BIT_PREC_SEL]
      && presc_last == 8'h03 |=> !count_tick_o [*3])
    else $error("Precision prescaler tick spacing wrong");
  a_accum_runs: assert property (accum_enable_i && !wait_stop |=> accum_run_o)
    else $error("Accumulator stopped without wait stop");
endmodule

/* pkg/tocc_pkg.sv */
// Constants and carrier types for the timer output compare control block.
// Assumes an 8-bit register port with 6-bit byte addresses and one bus clock.
package tocc_pkg;
  // Register offsets
  localparam logic [5:0] ADDR_FORCE = 6'h01;
  localparam logic [5:0] ADDR_CNT_HI = 6'h04;
  localparam logic [5:0] ADDR_CNT_LO = 6'h05;
  localparam logic [5:0] ADDR_SYS_CTRL1 = 6'h06;
  localparam logic [5:0] ADDR_OVF_TOGGLE = 6'h07;
  localparam logic [5:0] ADDR_ACT_UPPER = 6'h08;
  localparam logic [5:0] ADDR_ACT_LOWER = 6'h09;
  localparam logic [5:0] ADDR_CHAN_FLAGS = 6'h0e;
  localparam logic [5:0] ADDR_OVF_FLAGS = 6'h0f;
  localparam logic [5:0] ADDR_CHAN_FIRST = 6'h10;
  localparam logic [5:0] ADDR_CHAN_LAST = 6'h1f;
  localparam logic [5:0] ADDR_ACC_CNT_HI = 6'h22;
  localparam logic [5:0] ADDR_ACC_CNT_LO = 6'h23;
  // Control register field positions, overflow flag bit and control read mask
  localparam int BIT_COUNT_EN = 7;
  localparam int BIT_STOP_WAIT = 6;
  localparam int BIT_STOP_FRZ = 5;
  localparam int BIT_FAST_CLR = 4;
  localparam int BIT_PREC_SEL = 3;
  localparam int BIT_OVF_FLAG = 7;
  localparam logic [7:0] CTRL_WR_MASK = 8'hf8;
  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic [7:0] RST_TOGGLE = 8'h00;
  localparam logic [15:0] RST_ACTION = 16'h0000;
  // Timing counts
  localparam logic [5:0] DIV64_LAST = 6'h3f;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tocc_bus_t;

  typedef struct packed {
    logic [7:0] compare_match;
    logic overflow;
  } tocc_event_t;
endpackage

/* tb/tocc_partner.sv */
// Far side of the block: main counter, pulse accumulator count and timer port pins.
// Assumes the block's tick outputs; the bench may add event pulses of its own.
`timescale 1ns/1ps
module tocc_partner #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input logic ref_clk_i,
  input logic rst_i,
  // Ticks from the block
  input logic count_tick_i,
  input logic div64_tick_i,
  // Pins from the block
  input logic [7:0] pin_i,
  input logic [7:0] pin_oe_i,
  // Bench injected events
  input tocc_pkg::tocc_event_t inj_i,
  // Events and pin levels
  output tocc_pkg::tocc_event_t event_o,
  output logic [7:0] pin_level_o,
  output logic [15:0] accum_count_o
);
  // Narrow counter so that wraps come often; the block never sees its width
  logic [CNT_W-1:0] cnt_q;
  tocc_pkg::tocc_event_t ev_q;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= '0;
      ev_q <= '0;
      accum_count_o <= '0;
    end else begin
      ev_q <= '0;
      if (count_tick_i) begin
        cnt_q <= cnt_q + 1'h1;
        ev_q.overflow <= &cnt_q;
        for (int n = 0; n < 8; n++) begin
          ev_q.compare_match[n] <= (cnt_q + 1'h1) == CNT_W'(n);
        end
      end
      if (div64_tick_i) begin
        accum_count_o <= accum_count_o + 16'h0001;
      end
    end
  end

  assign event_o = tocc_pkg::tocc_event_t'(ev_q | inj_i);
  // Undriven pins fall to the pull-up, never to the last driven value
  assign pin_level_o = (pin_i & pin_oe_i) | ~pin_oe_i;
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the timer output compare control block.
// Assumes the far-side model in tocc_partner and a 10 MHz bus clock.
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("mismatch t=%0t got %h exp %h", $time, (g), (e)); end end
module tb_top;
  logic ref_clk_i = 1'h0;
  logic rst_i = 1'h1;
  tocc_pkg::tocc_bus_t bus = '0;
  tocc_pkg::tocc_event_t inj = '0;
  tocc_pkg::tocc_event_t ev;
  logic wait_m = 1'h0, frz = 1'h0, acc_en = 1'h0;
  logic [7:0] mode = 8'h00, mask = 8'h00, odata = 8'h00, pdis = 8'h00, pps = 8'h03;
  logic [7:0] rdata, ch_clr, pin, oe, lvl, r, c_ch;
  logic [7:0] s_pin, s_lvl, s_oe;
  logic ctick, dtick, trun, arun, ovf_clr, aov_clr, ain_clr, c_ov;
  logic [1:0] c_ac;
  logic [15:0] acnt;
  int n_errors = 0;
  int n_tests = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  tocc_core tocc_core_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata),
    .wait_mode_i(wait_m), .freeze_mode_i(frz), .accum_enable_i(acc_en),
    .channel_mode_select_i(mode), .override_mask_i(mask), .override_data_i(odata),
    .pin_disconnect_bit_i(pdis), .legacy_prescaler_field_i(3'h0),
    .precision_prescaler_register_i(pps), .event_i(ev),
    .count_tick_o(ctick), .div64_tick_o(dtick), .timer_run_o(trun),
    .accum_run_o(arun), .channel_flag_clr_o(ch_clr), .overflow_flag_clr_o(ovf_clr),
    .accum_overflow_flag_clr_o(aov_clr), .accum_input_flag_clr_o(ain_clr),
    .channel_pin_o(pin), .channel_pin_oe_o(oe)
  );

  tocc_partner tocc_partner_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .count_tick_i(ctick), .div64_tick_i(dtick),
    .pin_i(pin), .pin_oe_i(oe), .inj_i(inj), .event_o(ev), .pin_level_o(lvl),
    .accum_count_o(acnt)
  );

  // One register access; read data and clear pulses are taken in the cycle after
  task automatic acc(input logic [5:0] a, input logic [7:0] d, input logic w);
    bus <= '{addr: a, wdata: d, wr: w, rd: !w};
    @(posedge ref_clk_i);
    bus <= '0;
    @(negedge ref_clk_i);
    r = rdata;
    c_ch = ch_clr;
    c_ov = ovf_clr;
    c_ac = {aov_clr, ain_clr};
    @(posedge ref_clk_i);
  endtask

  task automatic pulse(input logic [7:0] m, input logic o);
    inj <= '{compare_match: m, overflow: o};
    @(posedge ref_clk_i);
    inj <= '0;
    @(negedge ref_clk_i);
    s_pin = pin;
    s_lvl = lvl;
    s_oe = oe;
    @(posedge ref_clk_i);
  endtask

  // Settle long enough for the divide-by-64 phase, then count both ticks
  task automatic ticks(output int c, output int d);
    c = 0;
    d = 0;
    repeat (70) @(posedge ref_clk_i);
    repeat (128) begin
      @(negedge ref_clk_i);
      c += int'(ctick);
      d += int'(dtick);
    end
    @(posedge ref_clk_i);
  endtask

  task automatic final_report;
    if (n_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #2000000;
    n_errors++;
    final_report();
  end

  initial begin
    logic [5:0] ra [5] = '{6'h06, 6'h07, 6'h08, 6'h09, 6'h3f};
    logic [5:0] fa [3] = '{6'h10, 6'h04, 6'h23};
    logic [7:0] wv [3] = '{8'ha5, 8'h3c, 8'hc3};
    logic [3:0] ea = 4'hb;
    int c, d;
    repeat (2) @(posedge ref_clk_i);
    rst_i <= 1'h0;
    @(posedge ref_clk_i);
    foreach (ra[i]) begin
      acc(ra[i], 8'h00, 1'h0);
      `CHK(r, 8'h00)
    end
    acc(6'h06, 8'h1f, 1'h1);
    acc(6'h06, 8'h00, 1'h0);
    `CHK(r, 8'h18)
    acc(6'h06, 8'h10, 1'h1);
    acc(6'h06, 8'h00, 1'h0);
    `CHK(r, 8'h18)
    foreach (wv[i]) begin
      acc(6'h07 + 6'(i), wv[i], 1'h1);
      acc(6'h07 + 6'(i), 8'h00, 1'h0);
      `CHK(r, wv[i])
      acc(6'h07 + 6'(i), 8'h00, 1'h1);
    end
    mode <= 8'hfe;
    acc(6'h10, 8'h00, 1'h0);
    `CHK(c_ch, 8'h01)
    acc(6'h12, 8'h00, 1'h0);
    `CHK(c_ch, 8'h00)
    acc(6'h1e, 8'h00, 1'h1);
    `CHK(c_ch, 8'h80)
    acc(6'h05, 8'h00, 1'h0);
    `CHK(c_ov, 1'h1)
    acc(6'h04, 8'h00, 1'h1);
    `CHK(c_ov, 1'h1)
    acc(6'h22, 8'h00, 1'h0);
    `CHK(c_ac, 2'h3)
    acc_en <= 1'h1;
    acc(6'h0e, 8'h5a, 1'h1);
    `CHK(c_ch, 8'h5a)
    acc_en <= 1'h0;
    acc(6'h0e, 8'h5a, 1'h1);
    `CHK(c_ch, 8'h00)
    acc(6'h06, 8'h00, 1'h1);
    foreach (fa[i]) begin
      acc(fa[i], 8'h00, 1'h0);
      `CHK({c_ch, c_ov, c_ac}, 11'h000)
    end
    mode <= 8'hff;
    for (int k = 3; k >= 0; k--) begin
      acc(6'h09, 8'(k), 1'h1);
      pulse(8'h01, 1'h0);
      `CHK(s_lvl[0], ea[k])
      `CHK(s_oe[0], 1'(k != 0))
    end
    acc(6'h09, 8'h02, 1'h1);
    pdis <= 8'h01;
    pulse(8'h01, 1'h0);
    `CHK({s_oe[0], s_lvl[0]}, 2'h1)
    pdis <= 8'h00;
    acc(6'h07, 8'h02, 1'h1);
    pulse(8'h00, 1'h1);
    `CHK(s_pin[1], 1'h1)
    mode <= 8'hfd;
    pulse(8'h00, 1'h1);
    `CHK(s_pin[1], 1'h1)
    mode <= 8'hff;
    acc(6'h07, 8'h82, 1'h1);
    mask <= 8'h02; // Mask bit 7 kept clear for channel 7 own action
    pulse(8'h00, 1'h1);
    `CHK({s_pin[7], s_pin[1]}, 2'h2)
    mask <= 8'h82;
    pulse(8'h80, 1'h0);
    `CHK(s_pin[7], 1'h0)
    acc(6'h09, 8'h0c, 1'h1);
    pulse(8'h02, 1'h0);
    `CHK(s_pin[1], 1'h1)
    pulse(8'h80, 1'h0);
    `CHK(s_pin[1], 1'h0)
    odata <= 8'h02;
    acc(6'h09, 8'h08, 1'h1);
    pulse(8'h82, 1'h0);
    `CHK(s_pin[1], 1'h1)
    mode <= 8'h7f;
    odata <= 8'h00;
    pulse(8'h80, 1'h0);
    `CHK(s_pin[1], 1'h1)
    mode <= 8'hff;
    mask <= 8'h00; // Mask cleared so no channel 7 event overrides channel 0 or 1
    acc(6'h07, 8'h01, 1'h1);
    acc(6'h09, 8'h03, 1'h1);
    acc(6'h01, 8'h01, 1'h1);
    @(negedge ref_clk_i);
    `CHK(pin[0], 1'h1)
    @(posedge ref_clk_i);
    // Force lands on the same edge as the overflow, so the toggle must win
    bus <= '{addr: 6'h01, wdata: 8'h01, wr: 1'h1, rd: 1'h0};
    @(posedge ref_clk_i);
    bus <= '0;
    inj <= '{compare_match: 8'h00, overflow: 1'h1};
    @(posedge ref_clk_i);
    inj <= '0;
    @(negedge ref_clk_i);
    `CHK(pin[0], 1'h0)
    @(posedge ref_clk_i);
    acc(6'h07, 8'h00, 1'h1);
    acc_en <= 1'h1;
    acc(6'h06, 8'h80, 1'h1);
    ticks(c, d);
    `CHK(c, 32)
    `CHK(d, 2)
    `CHK(trun, 1'h1)
    frz <= 1'h1;
    acc(6'h06, 8'ha0, 1'h1);
    ticks(c, d);
    `CHK(c, 0)
    `CHK(d, 2)
    wait_m <= 1'h1;
    acc(6'h06, 8'hc0, 1'h1);
    ticks(c, d);
    `CHK(c + d, 0)
    `CHK(arun, 1'h0)
    wait_m <= 1'h0;
    frz <= 1'h0;
    acc(6'h06, 8'h00, 1'h1);
    ticks(c, d);
    `CHK(c + d, 0)
    `CHK(trun, 1'h0)
    final_report();
  end
endmodule
